// [rtl/panel_video_source.sv]
// Video source driving the four-channel panel input: sync, enable, pixels.
// Assumes ref_clk at 20 MHz, link_clk from the pixel clock generator,
// and panel power and backlight driven from the outputs below.
`timescale 1ns/1ns
`default_nettype none
`include "video_timing_cfg.svh"

module panel_video_source
	import video_timing_pkg::*;
#(
	parameter int PIX_W = 30,
	parameter int BL_ON_CYCLES = `MS_CYCLES(`BL_ON_DELAY_MS),
	parameter int BL_OFF_CYCLES = `MS_CYCLES(`BL_OFF_DELAY_MS)
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic link_clk,
	input wire logic run_req,
	input wire logic [1:0] format_sel,
	input wire logic mode_3d,
	output logic panel_power_on,
	output logic backlight_on,
	output logic running,
	output logic link_hsync,
	output logic link_vsync,
	output logic link_active_pixel_flag,
	output logic link_eye_left,
	output logic [4*PIX_W-1:0] link_pixels
);

	// ----------------------------------------------------------------
	// Reset release and power sequencing (reference domain)
	// ----------------------------------------------------------------
	logic [1:0] rst_sync_reg;
	logic rst_n;
	logic [1:0] ack_sync_reg;
	logic [1:0] req_meta_reg;
	power_state_t pwr_reg, pwr_next;
	logic [31:0] dly_reg, dly_next;
	logic video_en_reg;
	logic bl_reg;
	logic [1:0] fmt_reg;
	logic td_reg;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			rst_sync_reg <= 2'h0;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end
	assign rst_n = rst_sync_reg[1];

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			req_meta_reg <= 2'h0;
		else
			req_meta_reg <= {req_meta_reg[0], run_req};
	end
	wire logic req_s = req_meta_reg[1];
	wire logic dly_done = (dly_reg == 32'h0);

	// Backlight only while timing is stable on the link
	always_comb begin
		pwr_next = pwr_reg;
		dly_next = dly_done ? 32'h0 : dly_reg - 32'h1;
		unique case (pwr_reg)
			PWR_OFF: if (req_s) begin
				pwr_next = PWR_PANEL;
				dly_next = 32'(BL_ON_CYCLES);
			end
			PWR_PANEL: if (!req_s) begin
				pwr_next = PWR_OFF;
			end else if (dly_done && ack_sync_reg[1]) begin
				pwr_next = PWR_RUN;
			end
			PWR_RUN: if (!req_s) begin
				pwr_next = PWR_DOWN;
				dly_next = 32'(BL_OFF_CYCLES);
			end
			PWR_DOWN: if (dly_done) begin
				pwr_next = PWR_OFF;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pwr_reg <= PWR_OFF;
			dly_reg <= 32'h0;
			video_en_reg <= 1'b0;
			bl_reg <= 1'b0;
			fmt_reg <= 2'h0;
			td_reg <= 1'b0;
		end else begin
			pwr_reg <= pwr_next;
			dly_reg <= dly_next;
			video_en_reg <= (pwr_next != PWR_OFF);
			bl_reg <= (pwr_next == PWR_RUN);
			if (pwr_reg == PWR_OFF) begin
				fmt_reg <= format_sel;
				td_reg <= mode_3d;
			end
		end
	end

	assign panel_power_on = video_en_reg;
	assign backlight_on = bl_reg;
	assign running = bl_reg;

	// ----------------------------------------------------------------
	// Crossing into the link domain
	// ----------------------------------------------------------------
	// Format and mode are held steady whenever video is enabled
	logic [2:0] lrst_reg;
	logic lrst_n;
	logic [1:0] en_sync_reg;
	logic [2:0] cfg_a_reg, cfg_b_reg;
	logic en_l;

	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n)
			lrst_reg <= 3'h0;
		else
			lrst_reg <= {lrst_reg[1:0], 1'b1};
	end
	assign lrst_n = lrst_reg[2];

	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			en_sync_reg <= 2'h0;
			cfg_a_reg <= 3'h0;
			cfg_b_reg <= 3'h0;
		end else begin
			en_sync_reg <= {en_sync_reg[0], video_en_reg};
			cfg_a_reg <= {td_reg, fmt_reg};
			cfg_b_reg <= cfg_a_reg;
		end
	end
	assign en_l = en_sync_reg[1];

	// ----------------------------------------------------------------
	// Timing selection
	// ----------------------------------------------------------------
	function automatic axis_timing_t h_timing(input logic [1:0] f);
		axis_timing_t t;
		t = '{12'(`HW_ACTIVE_CLKS), 12'(`HW_LINE_TOTAL),
			12'(`HW_HSYNC_CLKS), 12'(`HW_HBP_CLKS)};
		if (f == FMT_FW_24)
			t = '{12'(`FW_ACTIVE_CLKS), 12'(`FW_LINE_TOTAL_24),
				12'(`FW_HSYNC_CLKS), 12'(`FW_HBP_CLKS)};
		else if (f == FMT_FW_30)
			t = '{12'(`FW_ACTIVE_CLKS), 12'(`FW_LINE_TOTAL_30),
				12'(`FW_HSYNC_CLKS), 12'(`FW_HBP_CLKS)};
		return t;
	endfunction : h_timing

	function automatic axis_timing_t v_timing(input logic [1:0] f,
			input logic td);
		axis_timing_t t;
		t = '{12'(`HW_ACTIVE_LINES), 12'(`HW_FRAME_TOTAL_100),
			12'(`HW_VSYNC_LINES), 12'(`HW_VBP_LINES)};
		if (f == FMT_HW_120 || td)
			t.total = 12'(`HW_FRAME_TOTAL_120);
		if (f[1] && !td)
			t = '{12'(`FW_ACTIVE_LINES), 12'(`FW_FRAME_TOTAL),
				12'(`FW_VSYNC_LINES), 12'(`FW_VBP_LINES)};
		return t;
	endfunction : v_timing

	// 3D forces half-width 120 Hz regardless of the format input
	wire logic td_l = cfg_b_reg[2];
	wire logic [1:0] fmt_l = td_l ? FMT_HW_120 : cfg_b_reg[1:0];
	wire axis_timing_t ht = h_timing(fmt_l);
	wire axis_timing_t vt = v_timing(fmt_l, td_l);

	// ----------------------------------------------------------------
	// Raster counters (link domain)
	// ----------------------------------------------------------------
	// Sync first, then back porch, active, and the rest as front porch
	logic [11:0] hcnt_reg, vcnt_reg;
	logic eye_reg;
	logic [15:0] pix_n_reg;
	video_sync_t sync_reg;
	logic [4*PIX_W-1:0] pix_reg;
	logic [1:0] ack_meta_reg;
	logic ack_l_reg;

	wire logic h_end = (hcnt_reg == ht.total - 12'h1);
	wire logic v_end = (vcnt_reg == vt.total - 12'h1);
	wire logic [11:0] h_act0 = ht.sync + ht.back;
	wire logic [11:0] v_act0 = vt.sync + vt.back;
	wire logic h_act = (hcnt_reg >= h_act0) &&
		(hcnt_reg < h_act0 + ht.active);
	wire logic v_act = (vcnt_reg >= v_act0) &&
		(vcnt_reg < v_act0 + vt.active);
	wire logic de_next = en_l && h_act && v_act;

	// Pixel test pattern: each lane gets its pixel index counted from 1, channel k = (n - 1) mod 4
	function automatic logic [PIX_W-1:0] pix_value(input logic [15:0] n);
		return PIX_W'(n);
	endfunction : pix_value

	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			hcnt_reg <= 12'h0;
			vcnt_reg <= 12'h0;
			eye_reg <= 1'b1;
			pix_n_reg <= 16'h0;
			sync_reg <= '0;
			pix_reg <= '0;
			ack_l_reg <= 1'b0;
		end else if (!en_l) begin
			// Unpowered: every line held low
			hcnt_reg <= 12'h0;
			vcnt_reg <= 12'h0;
			eye_reg <= 1'b1;
			pix_n_reg <= 16'h0;
			sync_reg <= '0;
			pix_reg <= '0;
			ack_l_reg <= 1'b0;
		end else begin
			hcnt_reg <= h_end ? 12'h0 : hcnt_reg + 12'h1;
			if (h_end)
				vcnt_reg <= v_end ? 12'h0 : vcnt_reg + 12'h1;
			if (h_end && v_end) begin
				eye_reg <= td_l ? ~eye_reg : 1'b1;
				ack_l_reg <= 1'b1;
			end
			if (h_end)
				pix_n_reg <= 16'h0;
			else if (de_next)
				pix_n_reg <= pix_n_reg + 16'h4;
			sync_reg.hsync <= (hcnt_reg < ht.sync);
			sync_reg.vsync <= (vcnt_reg < vt.sync);
			sync_reg.active_pixel_flag <= de_next;
			sync_reg.eye_left <= td_l ? eye_reg : 1'b0;
			for (int k = 0; k < 4; k++)
				pix_reg[k*PIX_W +: PIX_W] <= de_next ?
					pix_value(pix_n_reg + 16'(k + 1)) : '0;
		end
	end

	assign link_hsync = sync_reg.hsync;
	assign link_vsync = sync_reg.vsync;
	assign link_active_pixel_flag = sync_reg.active_pixel_flag;
	assign link_eye_left = sync_reg.eye_left;
	assign link_pixels = pix_reg;

	// First full frame done: level back to the reference domain
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			ack_meta_reg <= 2'h0;
		else
			ack_meta_reg <= {ack_meta_reg[0], ack_l_reg};
	end
	assign ack_sync_reg = ack_meta_reg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// rest on the pixel clock chosen for link_clk
	hsync_width_a: assert property (
		@(posedge link_clk) disable iff (!lrst_n)
		$rose(link_hsync) |-> link_hsync [*2])
		else $error("hsync narrower than two clocks");

	de_sync_excl_a: assert property (
		@(posedge link_clk) disable iff (!lrst_n)
		link_active_pixel_flag |-> !link_hsync && !link_vsync)
		else $error("enable overlaps sync");

	// Run length kept in a counter; a line-long delay would be unrolled
	logic [11:0] de_run_reg;

	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n)
			de_run_reg <= 12'h0;
		else if (sync_reg.active_pixel_flag)
			de_run_reg <= de_run_reg + 12'h1;
		else
			de_run_reg <= 12'h0;
	end

	// Lines cut by power-down are left out through en_l
	de_run_len_a: assert property (
		@(posedge link_clk) disable iff (!lrst_n)
		$fell(link_active_pixel_flag) && en_l && !fmt_l[1] &&
			$stable(cfg_b_reg)
		|-> de_run_reg == 12'(`HW_ACTIVE_CLKS))
		else $error("half-width line not 480 active clocks");

	de_run_fw_a: assert property (
		@(posedge link_clk) disable iff (!lrst_n)
		$fell(link_active_pixel_flag) && en_l && fmt_l[1] &&
			$stable(cfg_b_reg)
		|-> de_run_reg == 12'(`FW_ACTIVE_CLKS))
		else $error("full-width line not 960 active clocks");

	off_quiet_a: assert property (
		@(posedge link_clk) disable iff (!lrst_n)
		!en_l |=> !link_hsync && !link_vsync && link_pixels == '0)
		else $error("link driven while unpowered");

	bl_needs_panel_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		backlight_on |-> panel_power_on)
		else $error("backlight on without panel power");

	lane_order_a: assert property (
		@(posedge link_clk) disable iff (!lrst_n)
		link_active_pixel_flag |->
			link_pixels[2*PIX_W-1:PIX_W] == link_pixels[PIX_W-1:0] + 1)
		else $error("channel two not pixel after channel one");

	eye_toggle_a: assert property (
		@(posedge link_clk) disable iff (!lrst_n)
		en_l && td_l && h_end && v_end |=> ##1 $changed(link_eye_left))
		else $error("eye select did not alternate");

	bl_off_first_a: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		pwr_reg == PWR_RUN && !req_s |=> !backlight_on && panel_power_on)
		else $error("panel dropped with backlight");

endmodule : panel_video_source
`default_nettype wire

// [rtl/video_timing_cfg.svh]
// Timing constants for the four-channel panel video source.
// Assumes inclusion by bare name from the source module and the testbench.
`ifndef VIDEO_TIMING_CFG_SVH
`define VIDEO_TIMING_CFG_SVH

// Reference clock in kHz
`define REF_CLK_KHZ 20000
// Half-width format, per channel
`define HW_ACTIVE_CLKS 480
`define HW_LINE_TOTAL 550
`define HW_HSYNC_CLKS 2
`define HW_HBP_CLKS 5
`define HW_ACTIVE_LINES 1080
`define HW_FRAME_TOTAL_100 1350
`define HW_FRAME_TOTAL_120 1125
`define HW_VSYNC_LINES 4
`define HW_VBP_LINES 10
// Full-width format, per channel
`define FW_ACTIVE_CLKS 960
`define FW_LINE_TOTAL_24 1375
`define FW_LINE_TOTAL_30 1100
`define FW_HSYNC_CLKS 4
`define FW_HBP_CLKS 10
`define FW_ACTIVE_LINES 2160
`define FW_FRAME_TOTAL 2250
`define FW_VSYNC_LINES 8
`define FW_VBP_LINES 20
// Power sequencing delays, in ms
`define BL_ON_DELAY_MS 1
`define BL_OFF_DELAY_MS 1
`define MS_CYCLES(ms) ((ms) * `REF_CLK_KHZ)

`endif

// [rtl/video_timing_pkg.sv]
// Types shared by the panel video source.
// Assumes the timing header is on the include path.
package video_timing_pkg;

	typedef enum logic [1:0] {
		FMT_HW_100 = 2'b00,
		FMT_HW_120 = 2'b01,
		FMT_FW_24 = 2'b10,
		FMT_FW_30 = 2'b11
	} video_format_t;

	typedef struct packed {
		logic hsync;
		logic vsync;
		logic active_pixel_flag;
		logic eye_left;
	} video_sync_t;

	typedef struct packed {
		logic [11:0] active;
		logic [11:0] total;
		logic [11:0] sync;
		logic [11:0] back;
	} axis_timing_t;

	typedef enum logic [1:0] {
		PWR_OFF = 2'b00,
		PWR_PANEL = 2'b01,
		PWR_RUN = 2'b10,
		PWR_DOWN = 2'b11
	} power_state_t;

endpackage : video_timing_pkg

// [bench/panel_model.sv]
// Panel receiver model: measures line and frame timing seen on the link.
// Assumes all link signals change on link_clk, cleared while unpowered.
`timescale 1ns/1ns
`default_nettype none
module panel_model
	import video_timing_pkg::*;
#(
	parameter int PIX_W = 30
) (
	input wire logic link_clk,
	input wire logic power_on,
	input wire video_sync_t sync_in,
	input wire logic [4*PIX_W-1:0] pixels,
	output logic [11:0] line_total_clocks,
	output logic [11:0] active_clks,
	output logic [11:0] hsync_clks,
	output logic [11:0] back_clks,
	output logic [11:0] vsync_lines,
	output logic [11:0] h_blank,
	output logic full_width_format,
	output logic limit_err,
	output logic lane_err
);
	logic hs_q, vs_q, de_q;
	logic [11:0] hc, hw, bc, ac, vl, pn;
	wire logic h_rise = sync_in.hsync & ~hs_q;
	wire logic de_rise = sync_in.active_pixel_flag & ~de_q;
	wire logic [11:0] base = de_rise ? 12'h001 : pn;
	// Limits picked from the measured width
	wire logic [11:0] lo = full_width_format ? 12'h3DE : 12'h212;
	wire logic [11:0] hi = full_width_format ? 12'h5A0 : 12'h29E;
	assign h_blank = line_total_clocks - active_clks;

	always @(posedge link_clk) begin
		hs_q <= sync_in.hsync;
		vs_q <= sync_in.vsync;
		de_q <= sync_in.active_pixel_flag;
		hc <= h_rise ? 12'h001 : hc + 12'h001;
		hw <= h_rise ? 12'h001 : hw + 12'(sync_in.hsync);
		bc <= (hs_q & ~sync_in.hsync) ? 12'h001 : bc + 12'h001;
		if (!power_on) begin
			{line_total_clocks, active_clks, hsync_clks} <= '0;
			{back_clks, vsync_lines, full_width_format} <= '0;
			{limit_err, lane_err, vl} <= '0;
		end else begin
			if (h_rise) begin
				line_total_clocks <= hc;
				if (active_clks != 0 && (hc < lo || hc > hi)) begin
					limit_err <= 1'b1;
				end
			end
			if (hs_q & ~sync_in.hsync) begin
				hsync_clks <= hw;
			end
			if (de_rise) begin
				back_clks <= bc;
			end
			if (sync_in.vsync & ~vs_q) begin
				vl <= 12'h001;
			end else if (sync_in.vsync & h_rise) begin
				vl <= vl + 12'h001;
			end
			if (vs_q & ~sync_in.vsync) begin
				vsync_lines <= vl;
			end
			if (sync_in.active_pixel_flag) begin
				ac <= de_rise ? 12'h001 : ac + 12'h001;
				pn <= base + 12'h004;
				for (int k = 0; k < 4; k++) begin
					if (pixels[k*PIX_W +: PIX_W] !== PIX_W'(base + k)) begin
						lane_err <= 1'b1;
					end
				end
			end
			if (de_q & ~sync_in.active_pixel_flag) begin
				active_clks <= ac;
				full_width_format <= (ac == 12'h3C0);
			end
		end
	end
endmodule : panel_model
`default_nettype wire

// [bench/tb.sv]
// Testbench: runs every format through power-up, measure and power-down.
// Assumes the panel model on the link and the timing header on the path.
`timescale 1ns/1ns
`default_nettype none
`include "video_timing_cfg.svh"
module tb
	import video_timing_pkg::*;
;
	logic ref_clk, link_clk, resetn, run_req, mode_3d;
	logic [1:0] format_sel;
	logic pwr, bl, run, hs, vs, de, eye;
	logic [119:0] pix;
	logic [11:0] m_tot, m_act, m_hs, m_bk, m_vs, m_blk;
	logic m_full, m_lim, m_lane;
	video_sync_t sync_w;
	int seed, error_cnt, n_checks, r;
	assign sync_w = {hs, vs, de, eye};

	initial ref_clk = 0;
	always #25 ref_clk = ~ref_clk;
	initial link_clk = 0;
	always #16 link_clk = ~link_clk;

	panel_video_source #(.PIX_W(30), .BL_ON_CYCLES(20), .BL_OFF_CYCLES(20))
	dut_u (.ref_clk(ref_clk), .resetn(resetn), .link_clk(link_clk),
		.run_req(run_req), .format_sel(format_sel), .mode_3d(mode_3d),
		.panel_power_on(pwr), .backlight_on(bl), .running(run),
		.link_hsync(hs), .link_vsync(vs), .link_active_pixel_flag(de),
		.link_eye_left(eye), .link_pixels(pix));

	panel_model #(.PIX_W(30)) model_u (.link_clk(link_clk), .power_on(pwr),
		.sync_in(sync_w), .pixels(pix), .line_total_clocks(m_tot),
		.active_clks(m_act), .hsync_clks(m_hs), .back_clks(m_bk),
		.vsync_lines(m_vs), .h_blank(m_blk), .full_width_format(m_full),
		.limit_err(m_lim), .lane_err(m_lane));

	task chk_val(input logic [11:0] got, input logic [11:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_val

	task chk_bit(input logic got, input logic exp);
		chk_val({11'h000, got}, {11'h000, exp});
	endtask : chk_bit

	function automatic logic [11:0] pick(input logic f, input int a, b);
		return 12'(f ? a : b);
	endfunction : pick

	function automatic logic [11:0] exp_tot(input logic [1:0] f, input logic m);
		if (m || !f[1]) return 12'(`HW_LINE_TOTAL);
		return pick(f[0], `FW_LINE_TOTAL_30, `FW_LINE_TOTAL_24);
	endfunction : exp_tot

	task wait_power(input logic lvl);
		for (int i = 0; i < 100 && pwr !== lvl; i++) begin
			@(posedge ref_clk);
			#1;
		end
		chk_bit(pwr, lvl);
	endtask : wait_power

	task run_one(input logic [1:0] f, input logic m);
		logic w;
		logic [11:0] act;
		w = f[1] && !m;
		act = pick(w, `FW_ACTIVE_CLKS, `HW_ACTIVE_CLKS);
		@(posedge ref_clk) #2;
		format_sel = f;
		mode_3d = m;
		repeat (($random(seed) & 7) + 1) @(posedge ref_clk);
		#2 run_req = 1;
		wait_power(1'b1);
		for (int i = 0; i < 30000 && m_vs == 0; i++) @(posedge link_clk);
		@(posedge ref_clk) #2;
		// Changes while powered must be ignored
		format_sel = ~f;
		mode_3d = ~m;
		repeat (pick(w, 24, 14)) @(posedge hs);
		#1;
		chk_val(m_tot, exp_tot(f, m));
		chk_val(m_act, act);
		chk_val(m_blk, exp_tot(f, m) - act);
		chk_val(m_hs, pick(w, `FW_HSYNC_CLKS, `HW_HSYNC_CLKS));
		chk_val(m_bk, pick(w, `FW_HBP_CLKS, `HW_HBP_CLKS));
		chk_val(m_vs, pick(w, `FW_VSYNC_LINES, `HW_VSYNC_LINES));
		chk_bit(m_full, w);
		chk_bit(m_lim, 1'b0);
		chk_bit(m_lane, 1'b0);
		chk_bit(eye, m);
		chk_bit(bl, 1'b0);
		@(posedge ref_clk) #2 run_req = 0;
		wait_power(1'b0);
		repeat (10) @(posedge ref_clk);
		chk_bit(|{hs, vs, de, pix, bl}, 1'b0);
	endtask : run_one

	task print_verdict;
		$display("checks=%0d errors=%0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : print_verdict

	initial begin
		seed = 22170;
		error_cnt = 0;
		n_checks = 0;
		{resetn, run_req, mode_3d, format_sel} = '0;
		repeat (6) @(posedge ref_clk);
		#2 resetn = 1;
		repeat (8) @(posedge ref_clk);
		chk_bit(|{pwr, bl, run, hs, vs, de, pix}, 1'b0);
		r = $random(seed);
		for (int k = 0; k < 4; k++) run_one(2'(k) ^ r[1:0], 1'b0);
		run_one(2'($random(seed)), 1'b1);
		print_verdict;
	end

	initial begin
		#6000000;
		error_cnt++;
		print_verdict;
	end
endmodule : tb
`default_nettype wire
